// ==== design/ccb_proc_end.sv ====
// Processor end: issues cycles, drives coherency outputs
`timescale 1ns/1ps
module ccb_proc_end (
   input wire logic clk,
   input wire logic rst_n,
   ccb_if.proc bus,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqLinefill,
   input wire logic [ccb_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [ccb_pkg::DATA_W-1:0] reqWdata,
   output logic reqReady,
   output logic [ccb_pkg::DATA_W-1:0] rspData,
   output logic rspValid,
   input wire logic snoopHit,
   input wire logic snoopModified,
   output logic writeBackMode
);
   import ccb_pkg::*;
   typedef enum {S_IDLE, S_ADDR, S_DATA} ccb_pst_t;
   ccb_pst_t state;
   ccb_cyc_t cyc;
   logic fillCyc;
   logic [BEAT_W-1:0] beat;
   logic resetSeen;
   logic dirtyPend;
   logic dirty;
   logic hit;
   logic [ADDR_W-1:0] dirtyAddr;
   logic [ADDR_W-1:0] addrQ;
   logic [DATA_W-1:0] wdataQ;
   logic beatDone;
   logic lastBeat;

   assign beatDone = (state == S_DATA) && !bus.burstTransferDoneN;
   // R02 R04
   assign lastBeat = !fillCyc || bus.cacheabilityPermitN || (beat == LAST_BEAT);
   assign reqReady = (state == S_IDLE) && !dirtyPend && resetSeen;

   // Mode caught on first clock after reset release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resetSeen <= 1'b0;
         writeBackMode <= 1'b0;
      end else if (!resetSeen) begin
         resetSeen <= 1'b1;
         writeBackMode <= bus.copybackSelect; // R05
      end
   end

   // Cycle sequencing, write-back has priority
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= S_IDLE;
         cyc <= CCB_RD;
         fillCyc <= 1'b0;
         beat <= '0;
         addrQ <= '0;
         wdataQ <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               if (dirtyPend) begin
                  state <= S_ADDR;
                  cyc <= CCB_WB;
                  fillCyc <= 1'b1;
                  addrQ <= dirtyAddr;
                  beat <= '0;
               end else if (reqValid && resetSeen) begin
                  state <= S_ADDR;
                  cyc <= reqWrite ? CCB_WR : CCB_RD;
                  fillCyc <= reqLinefill && !reqWrite; // R01 R08
                  addrQ <= reqAddr;
                  wdataQ <= reqWdata;
                  beat <= '0;
               end
            end
            S_ADDR: state <= S_DATA;
            S_DATA: begin
               if (beatDone) begin
                  beat <= beat + 2'h1;
                  // Write-back always runs the whole line, whatever the permit says
                  if (cyc == CCB_WB ? beat == LAST_BEAT : lastBeat) begin
                     state <= S_IDLE;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Snoop tracking and dirty hit hold
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dirtyPend <= 1'b0;
         dirty <= 1'b0;
         hit <= 1'b0;
         dirtyAddr <= '0;
      end else begin
         if (bus.snoopStrobe && writeBackMode) begin
            hit <= snoopHit;
            if (snoopHit && snoopModified) begin
               dirty <= 1'b1; // R09
               dirtyPend <= 1'b1;
               dirtyAddr <= bus.snoopAddress;
            end
         end else if (state == S_IDLE && dirtyPend) begin
            dirtyPend <= 1'b0;
         end else if (dirty && cyc == CCB_WB && beatDone && beat == LAST_BEAT) begin
            dirty <= 1'b0; // R10 R11
            hit <= 1'b0;
         end
      end
   end

   // Read data capture
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rspData <= '0;
         rspValid <= 1'b0;
      end else begin
         rspValid <= beatDone && cyc == CCB_RD;
         if (beatDone && cyc == CCB_RD) begin
            rspData <= bus.readData;
         end
      end
   end

   // R06
   assign bus.addressStrobeN = !(state == S_ADDR);
   assign bus.address = addrQ;
   assign bus.writeNotRead = (cyc != CCB_RD);
   assign bus.writeData = wdataQ;
   assign bus.linefillIntentN = !((state != S_IDLE) && fillCyc && cyc == CCB_RD); // R01 R08
   assign bus.lastTransferN = !((state == S_DATA) &&
      (cyc == CCB_WB ? beat == LAST_BEAT : lastBeat)); // R04
   assign bus.snoopHitN = !(writeBackMode && hit); // R07
   assign bus.snoopDirtyHitN = !(writeBackMode && dirty); // R07 R09
endmodule : ccb_proc_end

// ==== include/ccb_pkg.sv ====
// Package of constants and types for the coherency bus signalling pair
// Contract
// R01: Linefill intent low only on line-fill reads
// R02: Linefill intent never implies burst continues
// R03: Controller grants or refuses cacheability
// R04: Single transfer with permit high ends last
// R05: Copyback mode latched at reset release
// R06: Coherency outputs always actively driven
// R07: Write-through holds both hit outputs high
// R08: Write-through intent toggles reads, high writes
// R09: Dirty hit low on snoop hitting modified
// R10: Dirty hit held until write-back completes
// R11: Dirty hit released before next strobe
// R12: Controller assumes no exact release clock
package ccb_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int LINE_BEATS = 4;
   localparam int BEAT_W = 2;
   localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
   localparam int RELEASE_DELAY = 1;
   typedef enum logic [1:0] {CCB_RD, CCB_WR, CCB_WB} ccb_cyc_t;
endpackage : ccb_pkg

// ==== include/ccb_if.sv ====
// Interface joining the processor end and the controller end
`timescale 1ns/1ps
interface ccb_if;
   import ccb_pkg::*;
   logic addressStrobeN;
   logic [ccb_pkg::ADDR_W-1:0] address;
   logic writeNotRead;
   logic linefillIntentN;
   logic lastTransferN;
   logic cacheabilityPermitN;
   logic burstTransferDoneN;
   logic [ccb_pkg::DATA_W-1:0] readData;
   logic [ccb_pkg::DATA_W-1:0] writeData;
   logic snoopHitN;
   logic snoopDirtyHitN;
   logic snoopStrobe;
   logic [ccb_pkg::ADDR_W-1:0] snoopAddress;
   logic copybackSelect;
   modport proc (output addressStrobeN, address, writeNotRead, linefillIntentN,
      lastTransferN, writeData, snoopHitN, snoopDirtyHitN,
      input cacheabilityPermitN, burstTransferDoneN, readData, snoopStrobe,
      snoopAddress, copybackSelect);
   modport ctrl (input addressStrobeN, address, writeNotRead, linefillIntentN,
      lastTransferN, writeData, snoopHitN, snoopDirtyHitN,
      output cacheabilityPermitN, burstTransferDoneN, readData, snoopStrobe,
      snoopAddress, copybackSelect);
endinterface : ccb_if

// ==== design/ccb_ctrl_end.sv ====
// Controller end: answers cycles, grants cacheability, issues snoops
`timescale 1ns/1ps
module ccb_ctrl_end (
   input wire logic clk,
   input wire logic rst_n,
   ccb_if.ctrl bus,
   input wire logic modeWriteBack,
   input wire logic allowCache,
   input wire logic [ccb_pkg::DATA_W-1:0] memRdata,
   output logic [ccb_pkg::ADDR_W-1:0] memAddr,
   output logic memWrite,
   output logic [ccb_pkg::DATA_W-1:0] memWdata,
   input wire logic snoopReq,
   input wire logic [ccb_pkg::ADDR_W-1:0] snoopReqAddr,
   output logic dirtySeen
);
   import ccb_pkg::*;
   logic busy;
   logic cacheGrant;
   logic [ADDR_W-1:0] snoopQ;
   logic snoopStb;

   // Cycle tracking and cacheability answer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cacheGrant <= 1'b0;
         memAddr <= '0;
         memWrite <= 1'b0;
         memWdata <= '0;
      end else begin
         memWrite <= busy && bus.writeNotRead;
         memWdata <= bus.writeData;
         if (!bus.addressStrobeN) begin
            busy <= 1'b1;
            memAddr <= bus.address;
            cacheGrant <= allowCache && !bus.linefillIntentN; // R03
         end else if (busy && !bus.lastTransferN) begin
            busy <= 1'b0;
         end
      end
   end

   // Snoop issue, dirty flag sampled each clock without timing assumptions
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         snoopStb <= 1'b0;
         snoopQ <= '0;
         dirtySeen <= 1'b0;
      end else begin
         snoopStb <= snoopReq && !busy;
         snoopQ <= snoopReqAddr;
         dirtySeen <= !bus.snoopDirtyHitN; // R12
      end
   end

   assign bus.copybackSelect = modeWriteBack; // R05
   assign bus.cacheabilityPermitN = !(busy && cacheGrant); // R02 R03
   assign bus.burstTransferDoneN = !busy;
   assign bus.readData = memRdata;
   assign bus.snoopStrobe = snoopStb;
   assign bus.snoopAddress = snoopQ;
endmodule : ccb_ctrl_end

// ==== tb/ccb_sva.sv ====
// Checker of the coherency signalling between both ends
`timescale 1ns/1ps
module ccb_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic addressStrobeN,
   input wire logic writeNotRead,
   input wire logic linefillIntentN,
   input wire logic lastTransferN,
   input wire logic cacheabilityPermitN,
   input wire logic burstTransferDoneN,
   input wire logic snoopHitN,
   input wire logic snoopDirtyHitN,
   input wire logic snoopStrobe,
   input wire logic copybackSelect
);
   logic wb;
   logic wbDone;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk) begin
      if (!rst_n) wb <= copybackSelect;
   end
   always_ff @(posedge clk) begin
      if (!rst_n || snoopStrobe || !addressStrobeN) wbDone <= 1'b0;
      else if (!burstTransferDoneN && !lastTransferN && writeNotRead) wbDone <= 1'b1;
   end
   sequence s_read;
      !addressStrobeN && !writeNotRead;
   endsequence
   sequence s_fill;
      s_read ##0 !linefillIntentN ##1 !cacheabilityPermitN && !burstTransferDoneN;
   endsequence
   a_single_ends: assert property (s_read ##1 cacheabilityPermitN && !burstTransferDoneN
      |-> !lastTransferN) else $error("single beat not last");
   a_fill_four: assert property (s_fill |-> lastTransferN ##1 lastTransferN[*2]
      ##1 !lastTransferN) else $error("fill burst length");
   a_intent_start: assert property ($fell(linefillIntentN) |-> !addressStrobeN
      && !writeNotRead) else $error("intent off a read");
   a_wt_hits: assert property (!wb |-> snoopHitN && snoopDirtyHitN)
      else $error("hit low in write-through");
   a_wt_write_intent: assert property (!wb && !addressStrobeN && writeNotRead
      |-> linefillIntentN) else $error("intent on write");
   a_dirty_cause: assert property ($fell(snoopDirtyHitN) |-> wb && ($past(snoopStrobe)
      || $past(snoopStrobe, 2))) else $error("dirty hit w/o snoop");
   a_dirty_hold: assert property ($rose(snoopDirtyHitN) |-> wbDone)
      else $error("dirty hit released early");
   a_dirty_by_strobe: assert property (!addressStrobeN && wbDone |-> snoopDirtyHitN)
      else $error("dirty hit at strobe");
endmodule : ccb_sva

// ==== tb/tb_top.sv ====
// Testbench joining both ends of the coherency bus
`timescale 1ns/1ps
module tb_top;
   import ccb_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqLinefill = 1'b0;
   logic reqReady, rspValid, writeBackMode, memWrite, dirtySeen, sawIntent;
   logic snoopHit = 1'b0, snoopModified = 1'b0, modeWriteBack = 1'b0, allowCache = 1'b1;
   logic snoopReq = 1'b0;
   logic [ADDR_W-1:0] reqAddr = 32'h00001000, snoopReqAddr = 32'h00001000, memAddr;
   logic [DATA_W-1:0] reqWdata = 64'h55aa, memRdata = 64'h0123456789abcdef, rspData, memWdata;
   int beats, n_mismatch, samples_checked;
   ccb_if bus();
   ccb_proc_end ccb_proc_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus.proc),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqLinefill(reqLinefill), .reqAddr(reqAddr),
      .reqWdata(reqWdata), .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
      .snoopHit(snoopHit), .snoopModified(snoopModified), .writeBackMode(writeBackMode));
   ccb_ctrl_end ccb_ctrl_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus.ctrl),
      .modeWriteBack(modeWriteBack), .allowCache(allowCache), .memRdata(memRdata),
      .memAddr(memAddr), .memWrite(memWrite), .memWdata(memWdata), .snoopReq(snoopReq),
      .snoopReqAddr(snoopReqAddr), .dirtySeen(dirtySeen));
   ccb_sva ccb_sva_inst (.clk(clk), .rst_n(rst_n), .addressStrobeN(bus.addressStrobeN),
      .writeNotRead(bus.writeNotRead), .linefillIntentN(bus.linefillIntentN),
      .lastTransferN(bus.lastTransferN), .cacheabilityPermitN(bus.cacheabilityPermitN),
      .burstTransferDoneN(bus.burstTransferDoneN), .snoopHitN(bus.snoopHitN),
      .snoopDirtyHitN(bus.snoopDirtyHitN), .snoopStrobe(bus.snoopStrobe),
      .copybackSelect(bus.copybackSelect));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (rspValid === 1'b1) beats++;
      if (bus.linefillIntentN === 1'b0) sawIntent = 1'b1;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic boot(input logic m);
      modeWriteBack <= m;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(writeBackMode, m);
   endtask : boot
   task automatic req(input logic w, input logic f, input int nb);
      int i = 0;
      beats = 0;
      sawIntent = 1'b0;
      reqWrite <= w;
      reqLinefill <= f;
      reqValid <= 1'b1;
      do begin @(negedge clk); i++; end while (reqReady !== 1'b1 && i < 50);
      @(posedge clk);
      reqValid <= 1'b0;
      repeat (12) @(posedge clk);
      chk(64'(beats), 64'(nb));
      chk(sawIntent, f && !w);
      if (!w) chk(rspData, memRdata);
      chk(64'(memAddr), 64'(reqAddr));
      if (w) chk(memWdata, reqWdata);
   endtask : req
   task automatic snoop(input logic dirty);
      snoopHit <= 1'b1;
      snoopModified <= 1'b1;
      snoopReq <= 1'b1;
      @(posedge clk);
      snoopReq <= 1'b0;
      repeat (3) @(posedge clk);
      chk(bus.snoopDirtyHitN, !dirty);
      chk(bus.snoopHitN, !dirty);
      chk(dirtySeen, dirty);
      repeat (12) @(posedge clk);
      chk(bus.snoopDirtyHitN, 1'b1);
   endtask : snoop
   task automatic t_wt;
      boot(1'b0);
      snoop(1'b0);
      req(1'b1, 1'b0, 0);
      req(1'b0, 1'b1, 4);
      $display("write-through test done");
   endtask : t_wt
   task automatic t_wb;
      boot(1'b1);
      allowCache <= 1'b0;
      req(1'b0, 1'b1, 1);
      allowCache <= 1'b1;
      req(1'b0, 1'b0, 1);
      snoop(1'b1);
      req(1'b0, 1'b1, 4);
      $display("write-back test done");
   endtask : t_wb
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      t_wt();
      t_wb();
      wrap_up();
   end
   initial begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule : tb_top
